// >>> inc/seq_pkg.sv
// shared widths, reset values and fuse-plane sizes for the sequencer
`default_nettype none
package seq_pkg;
   localparam int N_IN   = 16;  // external inputs
   localparam int N_ST   = 6;   // state register bits
   localparam int N_OUT  = 8;   // registered output bits
   localparam int N_PT   = 48;  // product terms
   localparam int N_PAIR = 14;  // set/reset sum-term pairs
   localparam int N_AIN  = N_IN + N_ST + 1; // and-array inputs incl. c term
   localparam int C_POS  = N_IN + N_ST;     // position of the c term input
   localparam logic [N_ST-1:0]  STATE_RST = 6'h3f; // power-up / preset
   localparam logic [N_OUT-1:0] OUT_RST   = 8'hff; // power-up / preset
   localparam logic [1:0]       DIAG_HI   = 2'h3;  // outputs 7:6 in diag
   localparam logic [N_OUT-1:0] OE_ALL    = 8'hff; // all outputs driven
   localparam logic [N_OUT-1:0] OE_NONE   = 8'h00; // all outputs floating
   // function of the dual-purpose pin, picked by the option fuse
   typedef enum logic {pin_preset, pin_out_ctrl} pin_mode_e;
endpackage
`default_nettype wire

// >>> inc/sr_bank_if.sv
// interface joining the sum-term logic to one s/r flip-flop bank
`default_nettype none
interface sr_bank_if #(parameter int W = 6);
   logic [W-1:0] set_t;  // set sum terms
   logic [W-1:0] rst_t;  // reset sum terms
   logic         force_hi; // preset: force all bits high
   logic [W-1:0] q;      // stored bits
   modport ctrl (output set_t, output rst_t, output force_hi, input q);
   modport bank (input set_t, input rst_t, input force_hi, output q);
endinterface
`default_nettype wire

// >>> logic/programmable_mealy_sequencer.sv
// programmable mealy sequencer: and/or fuse planes, s/r registers, pins
`default_nettype none
module programmable_mealy_sequencer (
   input  wire logic clk_i,                          // 100 mhz clock
   input  wire logic rst_n_i,                        // power-up, active low
   input  wire logic [seq_pkg::N_IN-1:0] external_inputs_i, // input pins
   input  wire logic diag_hv_i,                      // input 0 at high volt
   input  wire logic preset_ctrl_i,                  // dual-purpose pin
   input  wire seq_pkg::pin_mode_e pin_mode_i,       // option fuse
   input  wire logic [seq_pkg::N_PT-1:0][seq_pkg::N_AIN-1:0]
                     fuse_true_i,                    // 1: true input tied
   input  wire logic [seq_pkg::N_PT-1:0][seq_pkg::N_AIN-1:0]
                     fuse_comp_i,                    // 1: inverse tied
   input  wire logic [seq_pkg::N_PAIR-1:0][seq_pkg::N_PT-1:0]
                     fuse_set_i,                     // set sum terms
   input  wire logic [seq_pkg::N_PAIR-1:0][seq_pkg::N_PT-1:0]
                     fuse_rst_i,                     // reset sum terms
   input  wire logic [seq_pkg::N_PT-1:0] fuse_c_i,   // c sum term
   output logic [seq_pkg::N_OUT-1:0] registered_outputs_o, // pin levels
   output logic [seq_pkg::N_OUT-1:0] registered_oe_o,      // 1: driven
   output logic [seq_pkg::N_ST-1:0]  state_bits_o          // state view
);
   localparam int NI = seq_pkg::N_IN;
   localparam int NS = seq_pkg::N_ST;
   localparam int NO = seq_pkg::N_OUT;
   localparam int NP = seq_pkg::N_PT;
   localparam int NA = seq_pkg::N_AIN;

   // pin synchronisers, first stage read only by second stage and a_oe_ctrl
   logic [NI-1:0] in_s1;        // inputs, stage one
   logic [NI-1:0] in_s2;        // inputs, usable
   logic          diag_s1;      // diag, stage one
   logic          diag_s2;      // diag, usable
   logic          pin_s1;       // dual pin, stage one
   logic          pin_s2;       // dual pin, usable

   // fuse map is static during operation, so it is not synchronised
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_s1   <= '0;
         in_s2   <= '0;
         diag_s1 <= 1'b0;
         diag_s2 <= 1'b0;
         pin_s1  <= 1'b0;
         pin_s2  <= 1'b0;
      end else begin
         in_s1   <= external_inputs_i;
         in_s2   <= in_s1;
         diag_s1 <= diag_hv_i;
         diag_s2 <= diag_s1;
         pin_s1  <= preset_ctrl_i;
         pin_s2  <= pin_s1;
      end
   end

   // register banks, 14 pairs in all
   sr_bank_if #(.W(NS)) st_bus ();                   // state bits
   sr_bank_if #(.W(NO)) out_bus ();                  // output bits

   sr_bank #(.W(NS), .RST(seq_pkg::STATE_RST)) u_state (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .bus     (st_bus)
   );
   sr_bank #(.W(NO), .RST(seq_pkg::OUT_RST)) u_out (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .bus     (out_bus)
   );

   // pin function decode
   logic preset_act;            // preset mode and pin high
   logic out_off;               // output-control mode and pin high
   logic diag_act;              // diagnostics mode

   always_comb begin
      preset_act = (pin_mode_i == seq_pkg::pin_preset) && pin_s2;
      out_off    = (pin_mode_i == seq_pkg::pin_out_ctrl) && pin_s2;
      diag_act   = diag_s2;
   end

   // and-array inputs; the c slot is filled in a second pass
   logic [NA-1:0] ain;          // inputs with c term
   logic [NA-1:0] ain_raw;      // inputs, c slot forced 0
   logic [NP-1:0] pt_raw;       // products ignoring the c input
   logic [NP-1:0] pt;           // final products
   logic          c_term;       // complemented sum fed back

   // a product fed into the c term would loop through itself; products
   // are therefore first formed with the c input left out
   always_comb begin
      ain_raw = {1'b0, st_bus.q, in_s2};
      for (int p = 0; p < NP; p++) begin
         pt_raw[p] = &(~fuse_true_i[p][NA-2:0] | ain_raw[NA-2:0]) &
                     &(~fuse_comp_i[p][NA-2:0] | ~ain_raw[NA-2:0]);
      end
   end

   always_comb begin
      c_term = ~|(pt_raw & fuse_c_i);
      ain    = {c_term, st_bus.q, in_s2};
      for (int p = 0; p < NP; p++) begin
         pt[p] = &(~fuse_true_i[p] | ain) &
                 &(~fuse_comp_i[p] | ~ain);
      end
   end

   // or array: pairs 0..5 drive state, 6..13 drive outputs
   logic [NS-1:0] st_set;       // state set terms
   logic [NS-1:0] st_rst;       // state reset terms
   logic [NO-1:0] o_set;        // output set terms
   logic [NO-1:0] o_rst;        // output reset terms

   always_comb begin
      for (int k = 0; k < NS; k++) begin
         st_set[k] = |(pt & fuse_set_i[k]);
         st_rst[k] = |(pt & fuse_rst_i[k]);
      end
      for (int k = 0; k < NO; k++) begin
         o_set[k] = |(pt & fuse_set_i[NS+k]);
         o_rst[k] = |(pt & fuse_rst_i[NS+k]);
      end
   end

   // drive the banks; preset holds them high and blocks clocking
   always_comb begin
      st_bus.set_t     = st_set;
      st_bus.rst_t     = st_rst;
      st_bus.force_hi  = preset_act;
      out_bus.set_t    = o_set;
      out_bus.rst_t    = o_rst;
      out_bus.force_hi = preset_act;
   end

   // pin stage: diag substitutes pin values only, never the register
   always_comb begin
      if (diag_act) begin
         registered_outputs_o = {seq_pkg::DIAG_HI, st_bus.q};
      end else begin
         registered_outputs_o = out_bus.q;
      end
      registered_oe_o = out_off ? seq_pkg::OE_NONE
                                : seq_pkg::OE_ALL;
      state_bits_o    = st_bus.q;
   end

   // expected next values, for the checks below only
   logic [NS-1:0] exp_st;       // expected next state
   logic [NO-1:0] exp_out;      // expected next outputs

   always_comb begin
      exp_st  = (st_bus.q | (st_set & ~st_rst)) & ~(st_rst & ~st_set);
      exp_out = (out_bus.q | (o_set & ~o_rst)) & ~(o_rst & ~o_set);
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_preset_hold;
      preset_act |=> (st_bus.q == seq_pkg::STATE_RST) &&
                     (out_bus.q == seq_pkg::OUT_RST);
   endproperty
   a_preset_hold: assert property (p_preset_hold)
      else $error("preset did not hold registers high");

   property p_resume;
      $past(preset_act) && !preset_act |=> st_bus.q == $past(exp_st);
   endproperty
   a_resume: assert property (p_resume)
      else $error("state did not update on first edge after preset");

   property p_set_reset;
      !preset_act |=> (st_bus.q == $past(exp_st)) &&
                      (out_bus.q == $past(exp_out));
   endproperty
   a_set_reset: assert property (p_set_reset)
      else $error("s/r update wrong");

   property p_hold;
      !preset_act && ((st_set | st_rst) == '0) |=> $stable(st_bus.q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("state moved without a sum term");

   property p_diag_pins;
      diag_act |-> registered_outputs_o == {seq_pkg::DIAG_HI, st_bus.q};
   endproperty
   a_diag_pins: assert property (p_diag_pins)
      else $error("diagnostics pin values wrong");

   property p_diag_keep;
      diag_act && !preset_act |=> out_bus.q == $past(exp_out);
   endproperty
   a_diag_keep: assert property (p_diag_keep)
      else $error("diagnostics disturbed output register");

   property p_oe_ctrl;
      (pin_mode_i == seq_pkg::pin_out_ctrl) ##1 $past(pin_s1) |->
         registered_oe_o == seq_pkg::OE_NONE;
   endproperty
   a_oe_ctrl: assert property (p_oe_ctrl)
      else $error("outputs not floated by control pin");

   property p_preset_mode_oe;
      pin_mode_i == seq_pkg::pin_preset |-> registered_oe_o == seq_pkg::OE_ALL;
   endproperty
   a_preset_mode_oe: assert property (p_preset_mode_oe)
      else $error("outputs floated in preset mode");

   // no selected product true: the complemented sum must read high
   property p_c_idle;
      ((pt_raw & fuse_c_i) == '0) |-> c_term;
   endproperty
   a_c_idle: assert property (p_c_idle)
      else $error("c term not high with no selected product true");

   c_preset: cover property ($fell(preset_act));
   c_diag:   cover property (diag_act ##1 !diag_act);
   c_float:  cover property (out_off ##1 !out_off);
   c_change: cover property (!preset_act ##1 $changed(st_bus.q));
endmodule
`default_nettype wire

// >>> logic/sr_bank.sv
// bank of rising-edge set/reset flip-flops, preset high at power-up
`default_nettype none
module sr_bank #(
   parameter int           W   = 6,       // bank width
   parameter logic [W-1:0] RST = '1       // power-up value
) (
   input  wire logic clk_i,               // clock
   input  wire logic rst_n_i,             // power-up preset, active low
   sr_bank_if.bank   bus                  // sum terms in, bits out
);
   // each bit: set, reset, hold; both true also holds
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus.q <= RST;
      end else if (bus.force_hi) begin
         bus.q <= RST;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (bus.set_t[i] && !bus.rst_t[i]) begin
               bus.q[i] <= 1'b1;
            end else if (bus.rst_t[i] && !bus.set_t[i]) begin
               bus.q[i] <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/far_logic.sv
// surrounding logic that presents levels on the sequencer input pins
`default_nettype none
module far_logic (
   input  wire logic [15:0] level_i, // levels requested by the bench
   output logic [15:0]      pins_o   // levels seen on the input pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // plain level driver; pins are always driven, never left floating
   assign pins_o = level_i;
endmodule
`default_nettype wire

// >>> tb/tb_programmable_mealy_sequencer.sv
// self-checking bench for the programmable mealy sequencer
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_programmable_mealy_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic               clk_i = 1'b0;     // 100 mhz clock
   logic               rst_n_i = 1'b0;   // power-up preset
   logic               diag_hv_i = 1'b0; // diagnostics request
   logic               preset_ctrl_i = 1'b0; // dual-purpose pin
   seq_pkg::pin_mode_e pin_mode_i = seq_pkg::pin_preset; // option fuse
   logic [15:0]        lvl = 16'h0000;   // requested input levels
   logic [15:0]        pins;             // input pin levels
   logic [47:0][22:0]  ft;               // true and-plane fuses
   logic [47:0][22:0]  fc;               // inverse and-plane fuses
   logic [13:0][47:0]  fs;               // set or-plane fuses
   logic [13:0][47:0]  fr;               // reset or-plane fuses
   logic [47:0]        fcm;              // c term fuses
   logic [7:0]         q;                // output pin levels
   logic [7:0]         oe;               // output enables
   logic [5:0]         st;               // state view
   int                 fails = 0;        // mismatches
   int                 checked = 0;      // comparisons
   // free-running clock
   always #5 clk_i = ~clk_i;
   far_logic u_far_logic (.level_i(lvl), .pins_o(pins));
   programmable_mealy_sequencer u_programmable_mealy_sequencer (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .external_inputs_i(pins),
      .diag_hv_i(diag_hv_i), .preset_ctrl_i(preset_ctrl_i),
      .pin_mode_i(pin_mode_i), .fuse_true_i(ft), .fuse_comp_i(fc),
      .fuse_set_i(fs), .fuse_rst_i(fr), .fuse_c_i(fcm),
      .registered_outputs_o(q), .registered_oe_o(oe), .state_bits_o(st));
   // unused products tie one input both ways so they stay false
   task automatic prog;
      ft = '0; fc = '0; fs = '0; fr = '0; fcm = '0;
      for (int p = 6; p < 48; p++) begin
         ft[p][0] = 1'b1;
         fc[p][0] = 1'b1;
      end
      ft[0][0] = 1'b1; ft[1][1] = 1'b1; ft[2][3] = 1'b1;
      ft[3][22] = 1'b1; ft[4][4] = 1'b1; ft[5][16] = 1'b1; ft[5][5] = 1'b1;
      fs[0][0] = 1'b1; fs[6][0] = 1'b1; fr[0][1] = 1'b1; fr[6][1] = 1'b1;
      fcm[2] = 1'b1; fs[8][3] = 1'b1; fs[1][5] = 1'b1;
      for (int k = 0; k < 14; k++) fr[k][4] = 1'b1;
   endtask
   // inputs settle through two sync flops, so allow four edges
   task automatic drive(input logic [15:0] v);
      lvl = v;
      repeat (4) @(negedge clk_i);
   endtask
   task automatic t_reset;
      `CHK("state", 6'h3f, st)
      `CHK("outputs", 8'hff, q)
      `CHK("enables", 8'hff, oe)
   endtask
   task automatic t_clear;
      drive(16'h0018);
      `CHK("state", 6'h00, st)
      `CHK("outputs", 8'h00, q)
      drive(16'h0008);
      `CHK("held state", 6'h00, st)
   endtask
   task automatic t_set;
      drive(16'h0009);
      `CHK("state", 6'h01, st)
      `CHK("outputs", 8'h01, q)
      drive(16'h0028);
      `CHK("fed back state", 6'h03, st)
      drive(16'h000a);
      `CHK("state", 6'h02, st)
      `CHK("outputs", 8'h00, q)
   endtask
   task automatic t_cterm;
      drive(16'h0000);
      `CHK("c term output", 8'h04, q)
      `CHK("state", 6'h02, st)
   endtask
   task automatic t_diag;
      diag_hv_i = 1'b1;
      drive(16'h0000);
      `CHK("diag view", 8'hc2, q)
      drive(16'h0001);
      `CHK("diag view", 8'hc3, q)
      diag_hv_i = 1'b0;
      drive(16'h0008);
      `CHK("output register", 8'h05, q)
   endtask
   task automatic t_preset;
      preset_ctrl_i = 1'b1;
      drive(16'h0018);
      `CHK("preset state", 6'h3f, st)
      `CHK("preset outputs", 8'hff, q)
      preset_ctrl_i = 1'b0;
      drive(16'h0018);
      `CHK("state", 6'h00, st)
      `CHK("outputs", 8'h00, q)
   endtask
   task automatic t_oectrl;
      pin_mode_i = seq_pkg::pin_out_ctrl;
      preset_ctrl_i = 1'b1;
      drive(16'h0009);
      `CHK("enables", 8'h00, oe)
      `CHK("state", 6'h01, st)
      preset_ctrl_i = 1'b0;
      drive(16'h0008);
      `CHK("enables", 8'hff, oe)
      `CHK("outputs", 8'h01, q)
   endtask
   task automatic end_of_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      prog();
      // hold reset three cycles; the banks only see it at a clock edge,
      // since the declared low level raises no negedge event
      repeat (3) @(negedge clk_i);
      t_reset();
      rst_n_i = 1'b1;
      t_clear();
      t_set();
      t_cterm();
      t_diag();
      t_preset();
      t_oectrl();
      end_of_test();
   end
   // hang guard
   initial begin
      repeat (2000) @(posedge clk_i);
      fails++;
      end_of_test();
   end
endmodule
`default_nettype wire
